// ===== hw/tmu_consts.svh
`ifndef TMU_CONSTS_SVH
`define TMU_CONSTS_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define TMU_OFF_START    8'h00
`define TMU_OFF_OUTCTL   8'h04
`define TMU_SUB_RELOAD   2'h0
`define TMU_SUB_COUNT    2'h1
`define TMU_SUB_CTRL     2'h2
`define TMU_SUB_CAPT     2'h3
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define TMU_F_SRC_HI     2
`define TMU_F_EDGE_LO    3
`define TMU_F_EDGE_HI    4
`define TMU_F_UIE        5
`define TMU_F_CAP_LO     6
`define TMU_F_CAP_HI     7
`define TMU_F_UF         8
`define TMU_F_CF         9
// ----------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------
`define TMU_SRC_DIV4     3'h0
`define TMU_SRC_DIV16    3'h1
`define TMU_SRC_DIV64    3'h2
`define TMU_SRC_DIV256   3'h3
`define TMU_SRC_DIV1024  3'h4
`define TMU_SRC_RTC      3'h6
`define TMU_SRC_EXT      3'h7
`define TMU_CAP_IRQ      2'h3
`define TMU_RST_CFG      8'h00
`define TMU_RST_COUNT    32'hffff_ffff
`define TMU_PRE_BITS     10
`endif

// ===== hw/tmu_pkg.sv
package tmu_pkg;
	typedef logic [31:0] tmu_word_t;
	// interrupt source, in falling priority after none
	typedef enum logic [2:0] {
		TMU_IRQ_NONE,
		TMU_IRQ_UF0,
		TMU_IRQ_UF1,
		TMU_IRQ_UF2,
		TMU_IRQ_CAP2,
		TMU_IRQ_UF3,
		TMU_IRQ_UF4
	} tmu_irq_e;
endpackage

// ===== hw/tmu_sync.sv
`timescale 1ns/1ps
module tmu_sync (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic async_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	// two flops against metastability, a third for edge detection
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else if (ce) begin
			meta_r <= async_i;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level_o = sync_r;
	assign rise_o  = sync_r & ~prev_r;
	assign fall_o  = ~sync_r & prev_r;
endmodule

// ===== hw/tmu_chan.sv
`timescale 1ns/1ps
`include "tmu_consts.svh"
module tmu_chan
	import tmu_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      rst_n,
	input  wire logic      ce,
	input  wire logic      run,
	input  wire logic      tick,
	input  wire logic      wr_reload,
	input  wire logic      wr_count,
	input  wire tmu_word_t wdata,
	output tmu_word_t      count_o,
	output tmu_word_t      reload_o,
	output logic           underflow_o
);
	tmu_word_t count_r;
	tmu_word_t reload_r;

	// a tick at zero is the underflow
	assign underflow_o = run & tick & (count_r == 32'h0000_0000);

	// reload constant
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reload_r <= `TMU_RST_COUNT;
		end else if (ce && wr_reload) begin
			reload_r <= wdata;
		end
	end

	// down counter; a software write wins over a tick
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			count_r <= `TMU_RST_COUNT;
		end else if (ce) begin
			if (wr_count) begin
				count_r <= wdata;
			end else if (underflow_o) begin
				count_r <= reload_r;
			end else if (run && tick) begin
				count_r <= count_r - 32'h0000_0001;
			end
		end
	end

	assign count_o  = count_r;
	assign reload_o = reload_r;
endmodule

// ===== hw/tmu_top.sv
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "tmu_consts.svh"
// What this block does
// - internal sources count on the clock divided by 4, 16, 64, 256 or 1024
// - channels 0 to 2 count rising, falling or both edges of the pin
// - channels 0 to 2 may count on the real-time-clock output
// - only channel 2 has capture register, capture flag and capture interrupt
// - edge select decides which pin edge triggers a capture
// - capture does not operate in standby
// - capture loads the register only while the capture flag is 0
// - no new capture dma request until the previous one is done
// - underflow interrupt per channel, plus capture interrupt on channel 2
// - underflow interrupt while underflow flag and its enable are 1
// - capture interrupt while capture flag is 1 and capture control is 11
// - priority: uf0, uf1, uf2, capture 2, uf3, uf4
// - start and flag clears work while counting; other control bits are written too
// - a counter read colliding with a decrement returns the old value
// - underflow sets the flag, reloads the counter, keeps counting
// - source codes: 4, 16, 64, 256, 1024, reserved, clock, pin
// - edge codes: 00 rising, 01 falling, 1x both
// - a capture requests dma unless a request is still outstanding; capture code 00 off, 01 reserved
module tmu_top
	import tmu_pkg::*;
#(
	parameter int NCH = 5
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic [7:0] reg_addr,
	input  wire tmu_word_t  reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output tmu_word_t       reg_rdata,
	input  wire logic       standby,
	input  wire logic       timer_ext_clock_pin_i,
	output logic            timer_ext_clock_pin_o,
	output logic            timer_ext_clock_pin_oe_n,
	input  wire logic       rtc_clk_i,
	output logic            underflow_irq_ch0,
	output logic            underflow_irq_ch1,
	output logic            underflow_irq_ch2,
	output logic            underflow_irq_ch3,
	output logic            underflow_irq_ch4,
	output logic            capture_irq_ch2,
	output logic            irq_any,
	output tmu_irq_e        irq_src,
	output logic            dma_req,
	input  wire logic       dma_done
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [NCH-1:0]             start_r;
	logic                       outctl_r;
	logic [7:0]                 cfg_r [NCH];
	logic [NCH-1:0]             uf_flag_r;
	logic                       cap_flag_r;
	tmu_word_t                  cap_r;
	logic                       dma_req_r;
	tmu_word_t                  rdata_r;
	logic [`TMU_PRE_BITS-1:0]   pre_cnt_r;

	logic [4:0]     pre_tick;
	logic [NCH-1:0] tick_v;
	logic [NCH-1:0] uf_pulse;
	logic [NCH-1:0] wr_rel_v;
	logic [NCH-1:0] wr_cnt_v;
	logic [NCH-1:0] wr_ctl_v;
	tmu_word_t      cnt_v [NCH];
	tmu_word_t      rel_v [NCH];
	logic           pin_lvl;
	logic           pin_rise;
	logic           pin_fall;
	logic           rtc_lvl;
	logic           rtc_rise;
	logic [2:0]     ch_idx;
	logic           ch_hit;
	logic           cap_evt;
	logic [4:0]     uf_irq;
	tmu_word_t      rd_val;

	// edge select shared by counting and capture
	function automatic logic edge_hit(
		input logic [1:0] sel,
		input logic       r,
		input logic       f
	);
		return sel[1] ? (r | f) : (sel[0] ? f : r);
	endfunction

	// ----------------------------------------------------------------
	// pin and clock synchronisers
	// ----------------------------------------------------------------
	tmu_sync u_pin_sync (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.ce      (ce),
		.async_i (timer_ext_clock_pin_i),
		.level_o (pin_lvl),
		.rise_o  (pin_rise),
		.fall_o  (pin_fall)
	);

	tmu_sync u_rtc_sync (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.ce      (ce),
		.async_i (rtc_clk_i),
		.level_o (rtc_lvl),
		.rise_o  (rtc_rise),
		.fall_o  ()
	);

	// when enabled as output the pin carries the sampled clock level
	assign timer_ext_clock_pin_o    = rtc_lvl;
	assign timer_ext_clock_pin_oe_n = ~outctl_r;

	// ----------------------------------------------------------------
	// prescaler
	// ----------------------------------------------------------------
	// one shared free-running divider keeps all channels phase aligned
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pre_cnt_r <= '0;
		end else if (ce) begin
			pre_cnt_r <= pre_cnt_r + `TMU_PRE_BITS'(1);
		end
	end

	assign pre_tick[0] = &pre_cnt_r[1:0];
	assign pre_tick[1] = &pre_cnt_r[3:0];
	assign pre_tick[2] = &pre_cnt_r[5:0];
	assign pre_tick[3] = &pre_cnt_r[7:0];
	assign pre_tick[4] = &pre_cnt_r[9:0];

	// ----------------------------------------------------------------
	// count source per channel
	// ----------------------------------------------------------------
	// only the clock source keeps running in standby
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			unique case (cfg_r[i][`TMU_F_SRC_HI:0])
				`TMU_SRC_DIV4:    tick_v[i] = pre_tick[0] & ~standby;
				`TMU_SRC_DIV16:   tick_v[i] = pre_tick[1] & ~standby;
				`TMU_SRC_DIV64:   tick_v[i] = pre_tick[2] & ~standby;
				`TMU_SRC_DIV256:  tick_v[i] = pre_tick[3] & ~standby;
				`TMU_SRC_DIV1024: tick_v[i] = pre_tick[4] & ~standby;
				`TMU_SRC_RTC:     tick_v[i] = (i < 3) & rtc_rise;
				`TMU_SRC_EXT:     tick_v[i] = (i < 3) & ~standby
					& edge_hit(cfg_r[i][`TMU_F_EDGE_HI:`TMU_F_EDGE_LO],
					pin_rise, pin_fall);
				default:          tick_v[i] = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	// channel blocks sit every 16 bytes from offset 0x10
	assign ch_idx = reg_addr[6:4] - 3'h1;
	assign ch_hit = ~reg_addr[7] & (reg_addr[6:4] != 3'h0)
		& (ch_idx < 3'(NCH)) & (reg_addr[1:0] == 2'h0);

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			wr_rel_v[i] = reg_wr & ch_hit & (ch_idx == 3'(i))
				& (reg_addr[3:2] == `TMU_SUB_RELOAD);
			wr_cnt_v[i] = reg_wr & ch_hit & (ch_idx == 3'(i))
				& (reg_addr[3:2] == `TMU_SUB_COUNT);
			wr_ctl_v[i] = reg_wr & ch_hit & (ch_idx == 3'(i))
				& (reg_addr[3:2] == `TMU_SUB_CTRL);
		end
	end

	// ----------------------------------------------------------------
	// channels
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		tmu_chan u_chan (
			.mclk        (mclk),
			.rst_n       (rst_n),
			.ce          (ce),
			.run         (start_r[g]),
			.tick        (tick_v[g]),
			.wr_reload   (wr_rel_v[g]),
			.wr_count    (wr_cnt_v[g]),
			.wdata       (reg_wdata),
			.count_o     (cnt_v[g]),
			.reload_o    (rel_v[g]),
			.underflow_o (uf_pulse[g])
		);
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	// start bits may change while counting
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			start_r  <= '0;
			outctl_r <= 1'b0;
		end else if (ce && reg_wr) begin
			if (reg_addr == `TMU_OFF_START) begin
				start_r <= reg_wdata[NCH-1:0];
			end
			if (reg_addr == `TMU_OFF_OUTCTL) begin
				outctl_r <= reg_wdata[0];
			end
		end
	end

	// configuration; capture control exists on channel 2 only
	always_ff @(posedge mclk) begin
		for (int i = 0; i < NCH; i++) begin
			if (!rst_n) begin
				cfg_r[i] <= `TMU_RST_CFG;
			end else if (ce && wr_ctl_v[i]) begin
				cfg_r[i] <= (i == 2) ? reg_wdata[7:0]
					: {2'b00, reg_wdata[5:0]};
			end
		end
	end

	// underflow flags: set beats a clear in the same cycle, writing 1 keeps
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			uf_flag_r <= '0;
		end else if (ce) begin
			for (int i = 0; i < NCH; i++) begin
				uf_flag_r[i] <= uf_pulse[i] | (uf_flag_r[i]
					& ~(wr_ctl_v[i] & ~reg_wdata[`TMU_F_UF]));
			end
		end
	end

	// ----------------------------------------------------------------
	// input capture on channel 2
	// ----------------------------------------------------------------
	// capture code 1x enables; 01 is reserved and treated as off
	assign cap_evt = cfg_r[2][`TMU_F_CAP_HI] & ~standby
		& edge_hit(cfg_r[2][`TMU_F_EDGE_HI:`TMU_F_EDGE_LO],
		pin_rise, pin_fall);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cap_flag_r <= 1'b0;
		end else if (ce) begin
			cap_flag_r <= cap_evt | (cap_flag_r
				& ~(wr_ctl_v[2] & ~reg_wdata[`TMU_F_CF]));
		end
	end

	// a held flag protects the earlier capture from being overwritten
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cap_r <= 32'h0000_0000;
		end else if (ce && cap_evt && !cap_flag_r) begin
			cap_r <= cnt_v[2];
		end
	end

	// one request outstanding; captures meanwhile are not queued
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dma_req_r <= 1'b0;
		end else if (ce) begin
			dma_req_r <= cap_evt | (dma_req_r & ~dma_done);
		end
	end

	assign dma_req = dma_req_r;

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	always_comb begin
		uf_irq = '0;
		for (int i = 0; i < NCH; i++) begin
			uf_irq[i] = uf_flag_r[i] & cfg_r[i][`TMU_F_UIE];
		end
	end

	assign underflow_irq_ch0 = uf_irq[0];
	assign underflow_irq_ch1 = uf_irq[1];
	assign underflow_irq_ch2 = uf_irq[2];
	assign underflow_irq_ch3 = uf_irq[3];
	assign underflow_irq_ch4 = uf_irq[4];
	assign capture_irq_ch2   = cap_flag_r
		& (cfg_r[2][`TMU_F_CAP_HI:`TMU_F_CAP_LO] == `TMU_CAP_IRQ);

	// highest pending source for the interrupt controller
	always_comb begin
		if (uf_irq[0])            irq_src = TMU_IRQ_UF0;
		else if (uf_irq[1])       irq_src = TMU_IRQ_UF1;
		else if (uf_irq[2])       irq_src = TMU_IRQ_UF2;
		else if (capture_irq_ch2) irq_src = TMU_IRQ_CAP2;
		else if (uf_irq[3])       irq_src = TMU_IRQ_UF3;
		else if (uf_irq[4])       irq_src = TMU_IRQ_UF4;
		else                      irq_src = TMU_IRQ_NONE;
	end

	assign irq_any = (irq_src != TMU_IRQ_NONE);

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// sampled before this edge's decrement lands, so a colliding read
	// sees the older count
	always_comb begin
		rd_val = 32'h0000_0000;
		if (reg_addr == `TMU_OFF_START) begin
			rd_val[NCH-1:0] = start_r;
		end else if (reg_addr == `TMU_OFF_OUTCTL) begin
			rd_val[0] = outctl_r;
		end else if (ch_hit) begin
			unique case (reg_addr[3:2])
				`TMU_SUB_RELOAD: rd_val = rel_v[ch_idx];
				`TMU_SUB_COUNT:  rd_val = cnt_v[ch_idx];
				`TMU_SUB_CTRL: begin
					rd_val[7:0]        = cfg_r[ch_idx];
					rd_val[`TMU_F_UF] = uf_flag_r[ch_idx];
					rd_val[`TMU_F_CF] = (ch_idx == 3'h2) & cap_flag_r;
				end
				`TMU_SUB_CAPT:   rd_val = (ch_idx == 3'h2) ? cap_r
					: 32'h0000_0000;
			endcase
		end
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_r <= 32'h0000_0000;
		end else if (ce) begin
			rdata_r <= reg_rd ? rd_val : 32'h0000_0000;
		end
	end

	assign reg_rdata = rdata_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	div4_period_a: assert property (
		(ce && pre_tick[0]) ##1 ce [*3] |=> pre_tick[0])
		else $error("divide by 4 tick period wrong");

	count_step_a: assert property (
		ce && start_r[1] && tick_v[1] && !wr_cnt_v[1] && cnt_v[1] != 0
		|=> cnt_v[1] == $past(cnt_v[1]) - 32'h0000_0001)
		else $error("counter did not step by one");

	uf_reload_a: assert property (
		ce && uf_pulse[0] && !wr_cnt_v[0] && !wr_rel_v[0]
		|=> cnt_v[0] == rel_v[0] && uf_flag_r[0])
		else $error("underflow did not reload and flag");

	uf_irq_a: assert property (
		ce && uf_pulse[1] && cfg_r[1][`TMU_F_UIE] && !wr_ctl_v[1]
		|=> underflow_irq_ch1 [*1] ##0 irq_any)
		else $error("underflow interrupt missing");

	cap_hold_a: assert property (
		ce && cap_evt && cap_flag_r |=> $stable(cap_r))
		else $error("capture overwrote held value");

	cap_load_a: assert property (
		ce && cap_evt && !cap_flag_r |=> cap_r == $past(cnt_v[2]) && cap_flag_r)
		else $error("capture value not loaded");

	dma_once_a: assert property (
		$rose(dma_req_r) |-> $past(cap_evt))
		else $error("dma request without capture");

	dma_hold_a: assert property (
		ce && dma_req_r && !dma_done |=> dma_req_r)
		else $error("dma request dropped early");

	cap_irq_a: assert property (
		capture_irq_ch2 |-> cap_flag_r && cfg_r[2][7:6] == 2'b11)
		else $error("capture interrupt without cause");

	stby_cap_a: assert property (
		standby |-> !cap_evt)
		else $error("capture in standby");

	irq_prio_a: assert property (
		uf_irq[1] && !uf_irq[0] |-> irq_src == TMU_IRQ_UF1)
		else $error("interrupt priority wrong");

	cnt_read_a: assert property (
		ce && reg_rd && reg_addr == 8'h14 |=> reg_rdata == $past(cnt_v[0]))
		else $error("counter read not pre-decrement value");

	uf_cover_c: cover property (ce && uf_pulse[0]);
	cap_cover_c: cover property (ce && cap_evt && !cap_flag_r);
	dma_cover_c: cover property (dma_req_r ##[1:20] dma_done);
	read_hit_c: cover property (ce && reg_rd && tick_v[0] && start_r[0]);
endmodule

// ===== tb/tmu_partner.sv
`timescale 1ns/1ps
module tmu_partner
	import tmu_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       dma_req,
	output logic            dma_done,
	input  wire logic [5:0] dma_lat,
	output logic [7:0]      req_count,
	input  wire tmu_irq_e   irq_src,
	output tmu_irq_e        last_src,
	input  wire logic       ext_level,
	input  wire logic       pin_o,
	input  wire logic       pin_oe_n,
	output logic            pin_i
);
	logic       busy_r;
	logic       req_d_r;
	logic [5:0] wait_r;

	// the timer owns the pin only while its enable is low
	assign pin_i = pin_oe_n ? ext_level : pin_o;

	// dma controller: one answer per request; a slow delay shows dropped events
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dma_done  <= 1'b0;
			req_d_r   <= 1'b0;
			busy_r    <= 1'b0;
			wait_r    <= 6'h0;
			req_count <= 8'h00;
		end else begin
			dma_done <= 1'b0;
			req_d_r  <= dma_req;
			if (dma_req && !req_d_r) begin
				req_count <= req_count + 8'h01;
			end
			if (dma_req && !busy_r) begin
				busy_r <= 1'b1;
				wait_r <= dma_lat;
			end else if (wait_r == 6'h1) begin
				dma_done <= 1'b1;
				wait_r   <= 6'h0;
			end else if (wait_r != 6'h0) begin
				wait_r <= wait_r - 6'h1;
			end else if (!dma_req) begin
				busy_r <= 1'b0;
			end
		end
	end

	// interrupt controller: keeps the last source it was offered
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			last_src <= TMU_IRQ_NONE;
		end else if (irq_src != TMU_IRQ_NONE) begin
			last_src <= irq_src;
		end
	end
endmodule

// ===== tb/tb_tmu_top.sv
`timescale 1ns/1ps
`include "tmu_consts.svh"
module tb_tmu_top
	import tmu_pkg::*;
;
	// ------------------------------
	// signals
	// ------------------------------
	logic       mclk = 1'b0;
	logic       rst_n = 1'b0;
	logic       ce = 1'b1;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       standby = 1'b0;
	logic       ext_level = 1'b0;
	logic       rtc_clk = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [5:0] dma_lat = 6'h2;
	tmu_word_t  reg_wdata = 32'h0;
	tmu_word_t  reg_rdata;
	logic [4:0] uf_irq;
	logic       cap_irq, irq_any, dma_req, dma_done, pin_i, pin_o, pin_oe_n;
	logic [7:0] req_count;
	tmu_irq_e   irq_src, last_src;
	int         fail_count = 0, compares = 0, cycles = 0, seed = 64;

	tmu_top u_tmu_top (
		.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby(standby),
		.timer_ext_clock_pin_i(pin_i), .timer_ext_clock_pin_o(pin_o),
		.timer_ext_clock_pin_oe_n(pin_oe_n), .rtc_clk_i(rtc_clk),
		.underflow_irq_ch0(uf_irq[0]), .underflow_irq_ch1(uf_irq[1]),
		.underflow_irq_ch2(uf_irq[2]), .underflow_irq_ch3(uf_irq[3]),
		.underflow_irq_ch4(uf_irq[4]), .capture_irq_ch2(cap_irq), .irq_any(irq_any),
		.irq_src(irq_src), .dma_req(dma_req), .dma_done(dma_done));

	tmu_partner u_tmu_partner (
		.mclk(mclk), .rst_n(rst_n), .dma_req(dma_req), .dma_done(dma_done),
		.dma_lat(dma_lat), .req_count(req_count), .irq_src(irq_src), .last_src(last_src),
		.ext_level(ext_level), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_i(pin_i));

	// clock and hang guard; the whole run needs well under a third of the ceiling
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles += 1;
		if (cycles == 20000) begin
			fail_count += 1;
			give_verdict();
		end
	end

	// ------------------------------
	// bus and checking tasks
	// ------------------------------
	task automatic check(input tmu_word_t seen, input tmu_word_t exp);
		compares += 1;
		if (seen !== exp) begin
			fail_count += 1;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input tmu_word_t d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output tmu_word_t d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask

	task automatic rdchk(input logic [7:0] a, input tmu_word_t exp);
		tmu_word_t v;
		rd(a, v);
		check(v, exp);
	endtask

	task automatic fin(input string name);
		$display("test %s done", name);
	endtask

	task automatic give_verdict();
		$display("compares %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	function automatic logic [7:0] ra(input int ch, input logic [1:0] sub);
		return 8'(16 + 16 * ch + 4 * sub);
	endfunction

	// pending vector in falling priority: uf0, uf1, uf2, cap2, uf3, uf4
	function automatic tmu_irq_e prio(input logic [5:0] p);
		for (int i = 0; i < 6; i++) begin
			if (p[i]) begin
				return tmu_irq_e'(i + 1);
			end
		end
		return TMU_IRQ_NONE;
	endfunction

	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		tmu_word_t  v, c1, c2, capexp, ctl;
		int         d, n0, re, fe;
		logic [5:0] p;
		logic [7:0] clr_a [6] = '{8'h18, 8'h28, 8'h38, 8'h38, 8'h48, 8'h58};
		tmu_word_t  clr_d [6] = '{32'h20, 32'h20, 32'h2e0, 32'he0, 32'h20, 32'h20};
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		check(irq_src, TMU_IRQ_NONE);
		check(dma_req, 0);
		check(pin_oe_n, 1);
		rdchk(`TMU_OFF_START, 0);
		rdchk(ra(2, `TMU_SUB_COUNT), `TMU_RST_COUNT);
		rdchk(8'h0c, 0);
		rdchk(ra(3, `TMU_SUB_CAPT), 0);
		wr(ra(0, `TMU_SUB_CTRL), 32'hc0);
		rdchk(ra(0, `TMU_SUB_CTRL), 0);
		wr(ra(2, `TMU_SUB_CAPT), $random(seed));
		rdchk(ra(2, `TMU_SUB_CAPT), 0);
		// a high clock level makes the driven pin value observable
		rtc_clk <= 1'b1;
		wr(`TMU_OFF_OUTCTL, 1);
		repeat (2) @(negedge mclk);
		check(pin_oe_n, 0);
		check(pin_o, 1);
		rtc_clk <= 1'b0;
		wr(`TMU_OFF_OUTCTL, 0);
		repeat (2) @(negedge mclk);
		check(pin_oe_n, 1);
		fin("reset");
		// any window of 2*d cycles holds exactly two prescaled ticks
		for (int s = 0; s < 5; s++) begin
			d = 4 << (2 * s);
			wr(`TMU_OFF_START, 0);
			wr(ra(0, `TMU_SUB_CTRL), s);
			wr(ra(0, `TMU_SUB_COUNT), 32'h8000_0000 | $random(seed));
			wr(`TMU_OFF_START, 1);
			rd(ra(0, `TMU_SUB_COUNT), c1);
			repeat (2 * d - 2) @(posedge mclk);
			rd(ra(0, `TMU_SUB_COUNT), c2);
			check(c1 - c2, 2);
		end
		wr(`TMU_OFF_START, 0);
		wr(ra(0, `TMU_SUB_CTRL), `TMU_SRC_RTC);
		wr(`TMU_OFF_START, 1);
		rd(ra(0, `TMU_SUB_COUNT), c1);
		repeat (3) begin
			repeat (8) @(posedge mclk);
			rtc_clk <= 1'b1;
			repeat (8) @(posedge mclk);
			rtc_clk <= 1'b0;
		end
		repeat (6) @(posedge mclk);
		rd(ra(0, `TMU_SUB_COUNT), c2);
		check(c1 - c2, 3);
		for (int e = 0; e < 4; e++) begin
			re = (e != 1);
			fe = (e != 0);
			wr(`TMU_OFF_START, 0);
			wr(ra(1, `TMU_SUB_CTRL), `TMU_SRC_EXT | (e << 3));
			wr(`TMU_OFF_START, 2);
			rd(ra(1, `TMU_SUB_COUNT), c1);
			repeat (2) begin
				repeat (4) @(posedge mclk);
				ext_level <= 1'b1;
				repeat (4) @(posedge mclk);
				ext_level <= 1'b0;
			end
			repeat (6) @(posedge mclk);
			rd(ra(1, `TMU_SUB_COUNT), c2);
			check(c1 - c2, 2 * (re + fe));
		end
		fin("sources");
		wr(`TMU_OFF_START, 0);
		v = 32'h10 + ($random(seed) & 32'hf);
		wr(ra(1, `TMU_SUB_RELOAD), v);
		wr(ra(1, `TMU_SUB_CTRL), 32'h20);
		wr(ra(1, `TMU_SUB_COUNT), 2);
		wr(`TMU_OFF_START, 2);
		for (int i = 0; i < 40 && uf_irq[1] !== 1'b1; i++) @(negedge mclk);
		check(irq_src, TMU_IRQ_UF1);
		rdchk(ra(1, `TMU_SUB_COUNT), v);
		rdchk(ra(1, `TMU_SUB_CTRL), 32'h120);
		check(last_src, TMU_IRQ_UF1);
		wr(ra(1, `TMU_SUB_CTRL), 32'h20);
		@(negedge mclk);
		check(uf_irq[1], 0);
		rdchk(ra(1, `TMU_SUB_CTRL), 32'h20);
		wr(`TMU_OFF_START, 0);
		wr(ra(1, `TMU_SUB_CTRL), 0);
		wr(ra(1, `TMU_SUB_COUNT), 0);
		wr(`TMU_OFF_START, 2);
		repeat (8) @(negedge mclk);
		check(uf_irq[1], 0);
		rdchk(ra(1, `TMU_SUB_CTRL), 32'h100);
		fin("underflow");
		// channel stopped so the captured value is known; slow dma on the last pass
		wr(`TMU_OFF_START, 0);
		for (int e = 0; e < 4; e++) begin
			re = (e != 1);
			fe = (e != 0);
			ctl = ((e == 2) ? 32'h80 : 32'hc0) | (e << 3);
			dma_lat <= (e == 3) ? 6'h28 : 6'(1 + ($random(seed) & 7));
			wr(ra(2, `TMU_SUB_CTRL), ctl);
			c1 = $random(seed);
			wr(ra(2, `TMU_SUB_COUNT), c1);
			n0 = req_count;
			ext_level <= 1'b1;
			repeat (20) @(posedge mclk);
			if (re) capexp = c1;
			rdchk(ra(2, `TMU_SUB_CAPT), capexp);
			c2 = $random(seed);
			wr(ra(2, `TMU_SUB_COUNT), c2);
			ext_level <= 1'b0;
			repeat (50) @(posedge mclk);
			if (fe && !re) capexp = c2;
			rdchk(ra(2, `TMU_SUB_CAPT), capexp);
			rdchk(ra(2, `TMU_SUB_CTRL), ctl | 32'h200);
			check(cap_irq, e != 2);
			check(req_count - n0, (e == 3) ? 1 : re + fe);
		end
		dma_lat <= 6'h2;
		standby <= 1'b1;
		wr(ra(2, `TMU_SUB_CTRL), 32'hc0);
		n0 = req_count;
		ext_level <= 1'b1;
		repeat (20) @(posedge mclk);
		check(req_count - n0, 0);
		rdchk(ra(2, `TMU_SUB_CTRL), 32'hc0);
		ext_level <= 1'b0;
		repeat (10) @(posedge mclk);
		standby <= 1'b0;
		ext_level <= 1'b1;
		repeat (20) @(negedge mclk);
		check(cap_irq, 1);
		fin("capture");
		// every source pending at once, then cleared from the top
		wr(`TMU_OFF_START, 0);
		for (int ch = 0; ch < 5; ch++) begin
			wr(ra(ch, `TMU_SUB_CTRL), (ch == 2) ? 32'h2e0 : 32'h20);
			wr(ra(ch, `TMU_SUB_COUNT), 0);
		end
		wr(`TMU_OFF_START, 32'h1f);
		repeat (10) @(negedge mclk);
		p = 6'h3f;
		for (int i = 0; i < 6; i++) begin
			check(irq_src, prio(p));
			check(irq_any, p != 6'h0);
			check({uf_irq[4:3], cap_irq, uf_irq[2:0]}, p);
			wr(clr_a[i], clr_d[i]);
			p[i] = 1'b0;
			@(negedge mclk);
		end
		check(irq_src, TMU_IRQ_NONE);
		fin("priority");
		give_verdict();
	end
endmodule
